// File: design/mac_regs.svh
// Register offsets, field positions, reset values and memory map of the guard
`ifndef MAC_REGS_SVH
`define MAC_REGS_SVH
`define MAC_A_STATUS 8'h00
`define MAC_A_CMD 8'h04
`define MAC_A_SEL 8'h08
`define MAC_A_FDATA 8'h0C
`define MAC_A_FCHK 8'h10
`define MAC_A_CARD 8'h14
`define MAC_A_LOCK 8'h18
`define MAC_A_SIDX 8'h1C
`define MAC_A_SRGT 8'h20
`define MAC_A_SSTA 8'h24
`define MAC_A_SEND 8'h28
`define MAC_A_SOFS 8'h2C
`define MAC_A_SSFR 8'h30
`define MAC_A_FWSFR 8'h34
`define MAC_A_EXC 8'h38
`define MAC_CMD_TEST 2'h1
`define MAC_CMD_FIRM 2'h2
`define MAC_CMD_APP 2'h3
`define MAC_F_DELIV 0
`define MAC_F_CARDOPT 1
`define MAC_F_CARDDIS 2
`define MAC_ST_FUSEOK 8
`define MAC_ST_FUSEERR 9
`define MAC_ST_DELIV 10
`define MAC_ST_CARDOFF 11
`define MAC_ST_LOCK 12
`define MAC_CRC_INIT 16'hFFFF
`define MAC_CRC_POLY 16'h1021
`define MAC_RST_SFR 16'h0000
`define MAC_ALL_SFR 16'hFFFF
`define MAC_ROM_TST_LO 24'h000000
`define MAC_ROM_TST_HI 24'h00FFFF
`define MAC_ROM_APP_LO 24'h010000
`define MAC_ROM_APP_HI 24'h03FFFF
`define MAC_RAM_FW_LO 24'h100000
`define MAC_RAM_FW_HI 24'h1007FF
`define MAC_RAM_APP_LO 24'h100800
`define MAC_RAM_APP_HI 24'h101FFF
`define MAC_NVM_FW_LO 24'h200000
`define MAC_NVM_FW_HI 24'h20FFFF
`define MAC_NVM_APP_LO 24'h210000
`define MAC_NVM_APP_HI 24'h223DFF
`define MAC_ROWS_LO 24'h223E00
`define MAC_ROWS_HI 24'h223FFF
`define MAC_ROWS_WORDS 20
`define MAC_RO_LAST 7'h07
`define MAC_WP_LAST 7'h0B
`define MAC_WO_LAST 7'h13
`define MAC_USER_ENTRY 24'h800000
`define MAC_SYSTEM_CALL_VECTOR 24'h00FF00
`define MAC_FIRMWARE_CALL_VECTOR 24'h00FF80
`define MAC_SEGS 64
`endif

// File: design/mac_pkg.sv
// Types shared by the mode guard and its CRC unit
package mac_pkg;
  typedef enum logic [4:0] {
    MAC_BOOT = 5'b00001,
    MAC_TEST = 5'b00010,
    MAC_FIRM = 5'b00100,
    MAC_SYS = 5'b01000,
    MAC_USER = 5'b10000
  } mac_mode_t;
  typedef enum logic [2:0] {
    RGT_NONE = 3'h0,
    RGT_R = 3'h1,
    RGT_RX = 3'h2,
    RGT_RW = 3'h3,
    RGT_RWX = 3'h4,
    RGT_SKIP = 3'h6,
    RGT_END = 3'h7
  } mac_rights_t;
  typedef enum logic [1:0] {
    ACC_RD = 2'h0,
    ACC_WR = 2'h1,
    ACC_FETCH = 2'h2,
    ACC_CALL = 2'h3
  } mac_kind_t;
  typedef enum logic [2:0] {
    EXC_NONE = 3'h0,
    EXC_UNIMPL = 3'h1,
    EXC_PART = 3'h2,
    EXC_SEG = 3'h3,
    EXC_ROWS = 3'h4,
    EXC_MODE = 3'h5
  } mac_exc_t;
  typedef struct packed {
    logic req;
    mac_kind_t kind;
    logic [23:0] addr;
    logic [31:0] wdata;
  } mac_cpu_req_t;
  typedef struct packed {
    logic req;
    logic write;
    logic fetch;
    logic [23:0] addr;
    logic [31:0] wdata;
  } mac_mem_req_t;
endpackage : mac_pkg

// File: design/mac_crc.sv
// CRC unit that checks the fuse-to-configuration transfer
`timescale 1ns/100ps
`include "mac_regs.svh"
module mac_crc
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clear,
  input wire logic i_valid,
  input wire logic [31:0] i_data,
  output logic [15:0] o_crc
);
  import mac_pkg::*;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [31:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 31; i >= 0; i--)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? `MAC_CRC_POLY : 16'h0000);
    return r;
  endfunction : crc_step

  always_ff @(posedge i_clock)
    if (i_sys_rst | i_clear)
      o_crc <= `MAC_CRC_INIT;
    else if (i_valid)
      o_crc <= crc_step(o_crc, i_data);
endmodule : mac_crc

// File: design/mac_guard.sv
// Mode guard, memory management unit and protected row control
`timescale 1ns/100ps
`include "mac_regs.svh"
module mac_guard
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input mac_pkg::mac_cpu_req_t i_cpu,
  output mac_pkg::mac_mem_req_t o_mem,
  output logic o_cpu_rvalid,
  output logic [31:0] o_cpu_rdata,
  output logic o_exception,
  output mac_pkg::mac_exc_t o_exc_cause,
  output mac_pkg::mac_mode_t o_mode,
  output logic [15:0] o_sfr_rights,
  output logic o_card_kill
);
  import mac_pkg::*;

  mac_mode_t mode;
  mac_mode_t next_mode;
  mac_exc_t next_exc;
  mac_exc_t exc_last;
  logic fuse_ok;
  logic fuse_err;
  logic fuse_first;
  logic [2:0] fuse_cfg;
  logic delivered;
  logic card_opt;
  logic card_dis_nv;
  logic wp_lock;
  logic [15:0] fw_sfr;
  logic [15:0] crc_val;
  logic [15:0] next_sfr;
  logic [5:0] seg_idx;
  logic [2:0] seg_rgt [`MAC_SEGS];
  logic [23:0] seg_sta [`MAC_SEGS];
  logic [23:0] seg_end [`MAC_SEGS];
  logic [23:0] seg_ofs [`MAC_SEGS];
  logic [15:0] seg_sfr [`MAC_SEGS];
  logic [31:0] rows [`MAC_ROWS_WORDS];
  logic [63:0] seg_hit;
  logic [64:0] seg_live;
  logic [255:0] wo_flat;

  function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_rng

  function automatic logic impl(input logic [23:0] a);
    return in_rng(a, `MAC_ROM_TST_LO, `MAC_ROM_APP_HI) | in_rng(a, `MAC_RAM_FW_LO, `MAC_RAM_APP_HI)
      | in_rng(a, `MAC_NVM_FW_LO, `MAC_ROWS_HI);
  endfunction : impl

  // Partitions are constants, so no software path can move them
  function automatic logic part_ok(input mac_mode_t m, input logic [23:0] a);
    logic fw;
    logic app;
    fw = in_rng(a, `MAC_ROM_TST_LO, `MAC_ROM_TST_HI) | in_rng(a, `MAC_RAM_FW_LO, `MAC_RAM_FW_HI)
      | in_rng(a, `MAC_NVM_FW_LO, `MAC_NVM_FW_HI) | in_rng(a, `MAC_ROWS_LO, `MAC_ROWS_HI);
    app = in_rng(a, `MAC_ROM_APP_LO, `MAC_ROM_APP_HI) | in_rng(a, `MAC_RAM_APP_LO, `MAC_RAM_APP_HI)
      | in_rng(a, `MAC_NVM_APP_LO, `MAC_NVM_APP_HI) | in_rng(a, `MAC_ROWS_LO, `MAC_ROWS_HI);
    case (m)
      MAC_TEST: return 1'b1;
      MAC_BOOT, MAC_FIRM: return fw;
      MAC_SYS, MAC_USER: return app;
      default: return 1'b0;
    endcase
  endfunction : part_ok

  // Of the rights that allow writes, ROM refuses a write only under RGT_RWX; a segment with RGT_RW lets it through
  function automatic logic rgt_ok(input logic [2:0] r, input mac_kind_t k, input logic rom);
    case (r)
      RGT_R: return k == ACC_RD;
      RGT_RX: return k != ACC_WR;
      RGT_RW: return k != ACC_FETCH;
      RGT_RWX: return !(rom && k == ACC_WR);
      default: return 1'b0;
    endcase
  endfunction : rgt_ok

  function automatic logic [5:0] first_hit(input logic [63:0] h);
    logic [5:0] idx;
    idx = 6'h00;
    for (int i = 63; i >= 0; i--)
      if (h[i])
        idx = i[5:0];
    return idx;
  endfunction : first_hit

  wire av_req = i_avs_read | i_avs_write;
  wire av_wr = i_avs_write & ~o_avs_waitrequest;
  wire [7:0] av_a = i_avs_address;
  wire [31:0] av_d = i_avs_writedata;
  wire in_boot = mode == MAC_BOOT;
  wire in_firm = mode == MAC_FIRM;
  wire in_sys = mode == MAC_SYS;
  wire user = mode == MAC_USER;
  wire app_sw = in_sys | user;
  wire w_cmd = av_wr & (av_a == `MAC_A_CMD);
  wire w_sel = av_wr & (av_a == `MAC_A_SEL);
  wire w_fdata = av_wr & (av_a == `MAC_A_FDATA) & in_boot;
  wire w_fchk = av_wr & (av_a == `MAC_A_FCHK) & in_boot;
  wire w_card = av_wr & (av_a == `MAC_A_CARD) & in_sys;
  wire w_lock = av_wr & (av_a == `MAC_A_LOCK) & app_sw;
  wire w_seg = av_wr & in_sys;
  wire w_fwsfr = av_wr & (av_a == `MAC_A_FWSFR) & (in_boot | in_firm);
  wire [1:0] cmd = av_d[1:0];
  wire crc_match = crc_val == av_d[15:0];
  wire card_blk = card_opt & (card_dis_nv | o_card_kill);

  wire [23:0] va = i_cpu.addr;
  wire call_ev = i_cpu.req & (i_cpu.kind == ACC_CALL);
  wire acc = i_cpu.req & (i_cpu.kind != ACC_CALL);
  wire cpu_wr = i_cpu.kind == ACC_WR;
  wire cpu_fetch = i_cpu.kind == ACC_FETCH;

  assign seg_live[0] = 1'b1;
  generate
    for (genvar g = 0; g < `MAC_SEGS; g++)
    begin : g_seg
      assign seg_live[g + 1] = seg_live[g] & (seg_rgt[g] != RGT_END);
      assign seg_hit[g] = seg_live[g + 1] & (seg_rgt[g] != RGT_SKIP) & in_rng(va, seg_sta[g], seg_end[g]);
    end
    for (genvar k = 0; k < 8; k++)
    begin : g_wo
      assign wo_flat[32 * k +: 32] = rows[12 + k];
    end
  endgenerate

  wire seg_found = |seg_hit;
  wire [5:0] seg_sel = first_hit(seg_hit);
  wire [23:0] pa = user ? va + seg_ofs[seg_sel] : va;
  wire is_rom = pa <= `MAC_ROM_APP_HI;
  wire is_rows = in_rng(pa, `MAC_ROWS_LO, `MAC_ROWS_HI);
  wire [6:0] row_w = pa[8:2];
  wire row_int = is_rows & (row_w <= `MAC_WO_LAST);
  wire row_ro = row_w <= `MAC_RO_LAST;
  wire row_wp = !row_ro & (row_w <= `MAC_WP_LAST);
  wire row_wo = !row_ro & !row_wp & row_int;
  wire row_pdc = !row_int;
  wire row_bad = row_pdc | (cpu_wr & (row_ro | (row_wp & wp_lock))) | cpu_fetch;
  wire seg_bad = !seg_found | !rgt_ok(seg_rgt[seg_sel], i_cpu.kind, is_rom);

  always_comb
  begin
    next_exc = EXC_NONE;
    if (call_ev & (va == `MAC_SYSTEM_CALL_VECTOR) & !user)
      next_exc = EXC_MODE;
    else if (!acc)
      next_exc = EXC_NONE;
    else if (user & seg_bad)
      next_exc = EXC_SEG;
    else if (!impl(pa) & (mode != MAC_TEST))
      next_exc = EXC_UNIMPL;
    else if (!part_ok(mode, pa))
      next_exc = EXC_PART;
    else if (is_rows & app_sw & row_bad)
      next_exc = EXC_ROWS;
  end

  wire acc_ok = acc & (next_exc == EXC_NONE);
  wire to_rows = acc_ok & row_int;

  always_comb
  begin
    next_mode = mode;
    case (mode)
      MAC_BOOT:
        if (w_cmd & fuse_ok & (cmd == `MAC_CMD_TEST) & !delivered)
          next_mode = MAC_TEST;
        else if (w_cmd & fuse_ok & (cmd == `MAC_CMD_FIRM))
          next_mode = MAC_FIRM;
      MAC_TEST:
        if (w_cmd & (cmd == `MAC_CMD_FIRM))
          next_mode = MAC_FIRM;
        else if (w_cmd & (cmd == `MAC_CMD_APP))
          next_mode = MAC_SYS;
      MAC_FIRM:
        if (w_cmd & (cmd == `MAC_CMD_APP) & !card_blk)
          next_mode = MAC_SYS;
      MAC_SYS:
        if ((w_sel & !av_d[0]) | (call_ev & (va == `MAC_USER_ENTRY)))
          next_mode = MAC_USER;
        else if (call_ev & (va == `MAC_FIRMWARE_CALL_VECTOR))
          next_mode = MAC_FIRM;
      MAC_USER:
        if (call_ev & (va == `MAC_SYSTEM_CALL_VECTOR))
          next_mode = MAC_SYS;
        else if (call_ev & (va == `MAC_FIRMWARE_CALL_VECTOR))
          next_mode = MAC_FIRM;
      default:
        next_mode = MAC_BOOT;
    endcase
  end

  // Boot, Test and System get every group, Firmware gets fw_sfr; User starts with none until its first fetch that raises no exception
  assign next_sfr = (next_mode == MAC_FIRM) ? fw_sfr :
    (next_mode != MAC_USER) ? `MAC_ALL_SFR :
    !user ? `MAC_RST_SFR :
    (acc_ok & cpu_fetch) ? seg_sfr[seg_sel] : o_sfr_rights;

  wire [31:0] st_word = {19'h00000, wp_lock, o_card_kill, delivered, fuse_err, fuse_ok, 3'h0, mode};
  wire [31:0] rd_mux = (av_a == `MAC_A_STATUS) ? st_word :
    (av_a == `MAC_A_SEL) ? {31'h00000000, in_sys} :
    (av_a == `MAC_A_SIDX) ? {26'h0000000, seg_idx} :
    (av_a == `MAC_A_SRGT) ? {29'h00000000, seg_rgt[seg_idx]} :
    (av_a == `MAC_A_SSTA) ? {8'h00, seg_sta[seg_idx]} :
    (av_a == `MAC_A_SEND) ? {8'h00, seg_end[seg_idx]} :
    (av_a == `MAC_A_SOFS) ? {8'h00, seg_ofs[seg_idx]} :
    (av_a == `MAC_A_SSFR) ? {16'h0000, seg_sfr[seg_idx]} :
    (av_a == `MAC_A_FWSFR) ? {16'h0000, fw_sfr} :
    (av_a == `MAC_A_EXC) ? {29'h00000000, exc_last} : 32'h00000000;

  mac_crc u_crc
  (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_clear(w_fchk),
    .i_valid(w_fdata),
    .i_data(av_d),
    .o_crc(crc_val)
  );

  // One wait state per access; read data is ready when waitrequest drops
  always_ff @(posedge i_clock)
  begin
    o_avs_waitrequest <= i_sys_rst | !(av_req & o_avs_waitrequest);
    o_avs_readdata <= i_sys_rst ? 32'h00000000 : (av_req & o_avs_waitrequest) ? rd_mux : o_avs_readdata;
  end

  always_ff @(posedge i_clock)
    if (i_sys_rst)
      mode <= MAC_BOOT;
    else
      mode <= next_mode;

  // Fuse values stay dormant until the checksum over them has matched
  always_ff @(posedge i_clock)
    if (i_sys_rst)
    begin
      fuse_ok <= 1'b0;
      fuse_err <= 1'b0;
      fuse_first <= 1'b1;
      fuse_cfg <= 3'h0;
      {delivered, card_opt, card_dis_nv} <= 3'h0;
    end
    else if (w_fchk & crc_match & !fuse_ok)
    begin
      fuse_ok <= 1'b1;
      fuse_first <= 1'b1;
      delivered <= fuse_cfg[`MAC_F_DELIV];
      card_opt <= fuse_cfg[`MAC_F_CARDOPT];
      card_dis_nv <= fuse_cfg[`MAC_F_CARDDIS];
    end
    else if (w_fchk)
    begin
      fuse_err <= !crc_match | fuse_err;
      fuse_first <= 1'b1;
    end
    else if (w_fdata & fuse_first)
    begin
      fuse_cfg <= av_d[2:0];
      fuse_first <= 1'b0;
    end

  always_ff @(posedge i_clock)
    if (i_sys_rst)
    begin
      o_card_kill <= 1'b0;
      wp_lock <= 1'b0;
      fw_sfr <= `MAC_RST_SFR;
      seg_idx <= 6'h00;
    end
    else
    begin
      o_card_kill <= o_card_kill | (w_card & card_opt & av_d[0]);
      wp_lock <= wp_lock | (w_lock & av_d[0]);
      fw_sfr <= w_fwsfr ? av_d[15:0] : fw_sfr;
      seg_idx <= (w_seg & (av_a == `MAC_A_SIDX)) ? av_d[5:0] : seg_idx;
    end

  // Table writes only from System mode
  always_ff @(posedge i_clock)
    if (i_sys_rst)
      for (int i = 0; i < `MAC_SEGS; i++)
        seg_rgt[i] <= RGT_END;
    else if (w_seg)
    begin
      if (av_a == `MAC_A_SRGT)
        seg_rgt[seg_idx] <= av_d[2:0];
      if (av_a == `MAC_A_SSTA)
        seg_sta[seg_idx] <= av_d[23:0];
      if (av_a == `MAC_A_SEND)
        seg_end[seg_idx] <= av_d[23:0];
      if (av_a == `MAC_A_SOFS)
        seg_ofs[seg_idx] <= av_d[23:0];
      if (av_a == `MAC_A_SSFR)
        seg_sfr[seg_idx] <= av_d[15:0];
    end

  // Row contents are lost on reset; a real part keeps them in the array
  always_ff @(posedge i_clock)
    if (i_sys_rst)
      for (int i = 0; i < `MAC_ROWS_WORDS; i++)
        rows[i] <= 32'h00000000;
    else if (to_rows & cpu_wr)
      // Write-once words only ever OR in data, whatever the mode, so a set bit survives
      rows[row_w[4:0]] <= row_wo ? (rows[row_w[4:0]] | i_cpu.wdata) : i_cpu.wdata;

  always_ff @(posedge i_clock)
    if (i_sys_rst)
    begin
      o_mem <= '0;
      o_cpu_rvalid <= 1'b0;
      o_cpu_rdata <= 32'h00000000;
      o_exception <= 1'b0;
      o_exc_cause <= EXC_NONE;
      exc_last <= EXC_NONE;
      o_sfr_rights <= `MAC_ALL_SFR;
    end
    else
    begin
      o_mem <= '{req: acc_ok & !row_int, write: cpu_wr, fetch: cpu_fetch, addr: pa, wdata: i_cpu.wdata};
      o_cpu_rvalid <= to_rows & !cpu_wr;
      o_cpu_rdata <= to_rows ? rows[row_w[4:0]] : o_cpu_rdata;
      o_exception <= next_exc != EXC_NONE;
      o_exc_cause <= next_exc;
      exc_last <= (next_exc != EXC_NONE) ? next_exc : exc_last;
      o_sfr_rights <= next_sfr;
    end

  assign o_mode = mode;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  sequence s_user_call;
    in_sys && call_ev && va == `MAC_USER_ENTRY;
  endsequence
  sequence s_fault;
    o_exception && !o_mem.req && !o_cpu_rvalid;
  endsequence

  property p_no_boot_return;
    !in_boot |=> !in_boot ##1 !in_boot;
  endproperty
  a_no_boot_return: assert property (p_no_boot_return) else $error("boot mode re-entered");
  property p_no_test_delivered;
    delivered |-> mode != MAC_TEST;
  endproperty
  a_no_test_delivered: assert property (p_no_test_delivered) else $error("test mode after delivery");
  property p_reset_boot;
    $fell(i_sys_rst) |-> in_boot && o_sfr_rights == `MAC_ALL_SFR;
  endproperty
  a_reset_boot: assert property (p_reset_boot) else $error("reset did not give boot mode");
  property p_fuse_crc;
    $rose(fuse_ok) |-> $past(w_fchk) && $past(crc_match);
  endproperty
  a_fuse_crc: assert property (p_fuse_crc) else $error("fuses taken without crc match");
  property p_rows_guard;
    acc && app_sw && is_rows && (row_pdc || (cpu_wr && row_ro)) |=> s_fault;
  endproperty
  a_rows_guard: assert property (p_rows_guard) else $error("protected row access not refused");
  property p_wo_sticky;
    ($past(wo_flat) & ~wo_flat) == 256'h0;
  endproperty
  a_wo_sticky: assert property (p_wo_sticky) else $error("write-once bit cleared");
  property p_card_block;
    card_blk && in_firm |=> mode != MAC_SYS;
  endproperty
  a_card_block: assert property (p_card_block) else $error("application started on disabled card");
  property p_part_super;
    acc && (in_boot || in_firm) && !part_ok(mode, va) |=> s_fault;
  endproperty
  a_part_super: assert property (p_part_super) else $error("firmware partition escaped");
  property p_seg_user_only;
    o_exc_cause == EXC_SEG |-> $past(mode) == MAC_USER;
  endproperty
  a_seg_user_only: assert property (p_seg_user_only) else $error("segment fault outside user");
  property p_reloc;
    acc_ok && user && !row_int |=> o_mem.req && o_mem.addr == $past(pa) && part_ok(MAC_USER, o_mem.addr);
  endproperty
  a_reloc: assert property (p_reloc) else $error("relocated access wrong or outside partition");
  property p_unimpl;
    acc && !user && mode != MAC_TEST && !impl(va) |=> o_exception && o_exc_cause == EXC_UNIMPL;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented access not flagged");
  property p_user_stays;
    user && !call_ev |=> user;
  endproperty
  a_user_stays: assert property (p_user_stays) else $error("privilege raised without call");
  property p_user_entry;
    s_user_call |=> user && !o_mem.req ##1 o_sfr_rights == `MAC_RST_SFR || $past(acc_ok);
  endproperty
  a_user_entry: assert property (p_user_entry) else $error("user entry call failed");
  property p_fw_rights;
    in_firm && next_mode == MAC_FIRM |=> o_sfr_rights == $past(fw_sfr);
  endproperty
  a_fw_rights: assert property (p_fw_rights) else $error("firmware register rights not passed");
endmodule : mac_guard

// File: bench/mac_cpu_model.sv
// CPU core model issuing one virtual access per call
`timescale 1ns/100ps
module mac_cpu_model
  import mac_pkg::*;
(
  input wire logic i_clock,
  input mac_pkg::mac_mem_req_t i_mem,
  input wire logic i_rvalid,
  input wire logic [31:0] i_rdata,
  input wire logic i_exc,
  input mac_pkg::mac_exc_t i_cause,
  output mac_pkg::mac_cpu_req_t o_cpu
);
  initial o_cpu = '0;
  // Flags {req,rvalid,exc,cause}; value is row data or physical address
  task automatic access(input mac_kind_t k, input logic [23:0] a, input logic [31:0] d,
    output logic [5:0] f, output logic [31:0] v);
    @(posedge i_clock);
    o_cpu <= '{1'b1, k, a, d};
    @(posedge i_clock);
    // Idle lines invert so a stale address never looks valid
    o_cpu <= '{1'b0, k, ~a, ~d};
    #1;
    f = {i_mem.req, i_rvalid, i_exc, i_cause};
    v = i_rvalid ? i_rdata : (i_mem.req ? {8'h00, i_mem.addr} : 32'h0);
  endtask : access
endmodule : mac_cpu_model

// File: bench/testbench.sv
// Self-checking bench for the mode guard
`timescale 1ns/100ps
`include "mac_regs.svh"
module testbench;
  import mac_pkg::*;
  localparam logic [5:0] GO = 6'h20;
  localparam logic [5:0] RV = 6'h10;
  localparam logic [23:0] RW0 = `MAC_ROWS_LO;
  logic i_clock, i_sys_rst, rd, wr, wreq, cpu_rv, exc, kill;
  logic [7:0] adr;
  logic [31:0] wd, rbus, cpu_rdata, q, v;
  logic [15:0] sfr;
  logic [5:0] f;
  mac_cpu_req_t cpu;
  mac_mem_req_t mem;
  mac_exc_t cause;
  mac_mode_t mode;
  int mismatches = 0;
  int compares = 0;
  mac_guard uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rbus), .o_avs_waitrequest(wreq), .i_cpu(cpu),
    .o_mem(mem), .o_cpu_rvalid(cpu_rv), .o_cpu_rdata(cpu_rdata), .o_exception(exc), .o_exc_cause(cause),
    .o_mode(mode), .o_sfr_rights(sfr), .o_card_kill(kill));
  mac_cpu_model core (.i_clock(i_clock), .i_mem(mem), .i_rvalid(cpu_rv), .i_rdata(cpu_rdata), .i_exc(exc),
    .i_cause(cause), .o_cpu(cpu));
  initial
  begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge i_clock); while (wreq !== 1'b0);
    q = rbus;
    rd <= 1'b0;
    wr <= 1'b0;
    #1;
  endtask : bus
  function automatic logic [15:0] crc(input logic [31:0] d);
    logic [15:0] c;
    c = `MAC_CRC_INIT;
    for (int i = 31; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `MAC_CRC_POLY : 16'h0);
    return c;
  endfunction : crc
  task acc(input mac_kind_t k, input logic [23:0] a, input logic [31:0] d, input logic [5:0] ef,
    input logic [31:0] ev);
    core.access(k, a, d, f, v);
    chk(f, ef);
    chk(v, ev);
  endtask : acc
  task rst;
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_clock);
    i_sys_rst <= 1'b0;
  endtask : rst
  task fuse(input logic [31:0] cfg, input logic [15:0] sum);
    bus(1'b1, `MAC_A_FDATA, cfg);
    bus(1'b1, `MAC_A_FCHK, {16'h0, sum});
    bus(1'b0, `MAC_A_STATUS, 32'h0);
  endtask : fuse
  task seg(input logic [5:0] i, input mac_rights_t r, input logic [23:0] s, e, o, input logic [15:0] p);
    bus(1'b1, `MAC_A_SIDX, {26'h0, i});
    bus(1'b1, `MAC_A_SRGT, {29'h0, r});
    bus(1'b1, `MAC_A_SSTA, {8'h0, s});
    bus(1'b1, `MAC_A_SEND, {8'h0, e});
    bus(1'b1, `MAC_A_SOFS, {8'h0, o});
    bus(1'b1, `MAC_A_SSFR, {16'h0, p});
  endtask : seg
  task t_test;
    rst;
    fuse(32'h0, crc(32'h0));
    chk(q[10:0], 11'h101);
    bus(1'b1, `MAC_A_CMD, `MAC_CMD_TEST);
    chk(mode, MAC_TEST);
    acc(ACC_RD, 24'h500000, 32'h0, GO, 32'h500000);
    bus(1'b1, `MAC_A_CMD, `MAC_CMD_FIRM);
    chk(mode, MAC_FIRM);
    bus(1'b1, `MAC_A_CMD, `MAC_CMD_TEST);
    chk(mode, MAC_FIRM);
    $display("test mode path done");
  endtask : t_test
  task t_firm;
    rst;
    fuse(32'h3, ~crc(32'h3));
    chk(q[10:8], 3'b010);
    fuse(32'h3, crc(32'h3));
    chk(q[10:8], 3'b111);
    bus(1'b1, `MAC_A_CMD, `MAC_CMD_TEST);
    chk(mode, MAC_BOOT);
    bus(1'b1, `MAC_A_CMD, `MAC_CMD_FIRM);
    bus(1'b1, `MAC_A_FWSFR, 32'h1234);
    acc(ACC_RD, 24'h100010, 32'h0, GO, 32'h100010);
    acc(ACC_WR, 24'h100900, 32'h1, 6'h0A, 32'h0);
    acc(ACC_FETCH, 24'h700000, 32'h0, 6'h09, 32'h0);
    chk(sfr, 16'h1234);
    bus(1'b1, `MAC_A_CMD, `MAC_CMD_APP);
    chk(mode, MAC_SYS);
    $display("firmware path done");
  endtask : t_firm
  task t_rows;
    acc(ACC_WR, RW0, 32'h5, 6'h0C, 32'h0);
    acc(ACC_RD, RW0, 32'h0, RV, 32'h0);
    acc(ACC_WR, RW0 + 24'h30, 32'h1, 6'h0, 32'h0);
    acc(ACC_WR, RW0 + 24'h30, 32'h2, 6'h0, 32'h0);
    acc(ACC_WR, RW0 + 24'h30, 32'h0, 6'h0, 32'h0);
    acc(ACC_RD, RW0 + 24'h30, 32'h0, RV, 32'h3);
    acc(ACC_WR, RW0 + 24'h20, 32'hA5, 6'h0, 32'h0);
    bus(1'b1, `MAC_A_LOCK, 32'h1);
    acc(ACC_WR, RW0 + 24'h20, 32'h5A, 6'h0C, 32'h0);
    acc(ACC_RD, RW0 + 24'h20, 32'h0, RV, 32'hA5);
    acc(ACC_RD, RW0 + 24'h50, 32'h0, 6'h0C, 32'h0);
    acc(ACC_RD, 24'h223DFC, 32'h0, GO, 32'h223DFC);
    acc(ACC_RD, 24'h200000, 32'h0, 6'h0A, 32'h0);
    chk(sfr, 16'hFFFF);
    $display("row areas done");
  endtask : t_rows
  task t_user;
    seg(6'd0, RGT_RW, 24'h0, 24'hFFF, 24'h100800, 16'h5);
    seg(6'd1, RGT_RX, 24'h1000, 24'h1FFF, 24'h00F000, 16'h9);
    seg(6'd2, RGT_RW, 24'h3000, 24'h3FFF, 24'h0FD000, 16'h1);
    bus(1'b0, `MAC_A_SEL, 32'h0);
    chk(q[0], 1'b1);
    bus(1'b1, `MAC_A_SEL, 32'h1);
    chk(mode, MAC_SYS);
    bus(1'b1, `MAC_A_SEL, 32'h0);
    chk(mode, MAC_USER);
    acc(ACC_RD, 24'h10, 32'h0, GO, 32'h100810);
    acc(ACC_WR, 24'h20, 32'h7, GO, 32'h100820);
    chk(mem.wdata, 32'h7);
    chk(mem.write, 1'b1);
    acc(ACC_FETCH, 24'h30, 32'h0, 6'h0B, 32'h0);
    acc(ACC_RD, 24'h4000, 32'h0, 6'h0B, 32'h0);
    acc(ACC_WR, 24'h1000, 32'h0, 6'h0B, 32'h0);
    chk(sfr, 16'h0000);
    acc(ACC_FETCH, 24'h1000, 32'h0, GO, 32'h10000);
    chk(mem.fetch, 1'b1);
    core.access(ACC_RD, 24'h3000, 32'h0, f, v);
    chk(f[5:3], 3'b001);
    chk(sfr, 16'h0009);
    bus(1'b0, `MAC_A_EXC, 32'h0);
    chk(q[2:0], EXC_PART);
    acc(ACC_CALL, `MAC_SYSTEM_CALL_VECTOR, 32'h0, 6'h0, 32'h0);
    chk(mode, MAC_SYS);
    acc(ACC_CALL, `MAC_SYSTEM_CALL_VECTOR, 32'h0, 6'h0D, 32'h0);
    acc(ACC_RD, 24'h10010, 32'h0, GO, 32'h10010);
    acc(ACC_CALL, `MAC_USER_ENTRY, 32'h0, 6'h0, 32'h0);
    chk(mode, MAC_USER);
    $display("user segmentation done");
  endtask : t_user
  task t_card;
    acc(ACC_CALL, `MAC_FIRMWARE_CALL_VECTOR, 32'h0, 6'h0, 32'h0);
    bus(1'b1, `MAC_A_CMD, `MAC_CMD_APP);
    bus(1'b1, `MAC_A_CARD, 32'h1);
    acc(ACC_CALL, `MAC_FIRMWARE_CALL_VECTOR, 32'h0, 6'h0, 32'h0);
    chk(kill, 1'b1);
    bus(1'b1, `MAC_A_CMD, `MAC_CMD_APP);
    chk(mode, MAC_FIRM);
    $display("card disable done");
  endtask : t_card
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  // Whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge i_clock);
    mismatches++;
    end_of_test;
  end
  initial
  begin
    i_sys_rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wd = 32'h0;
    t_test;
    t_firm;
    t_rows;
    t_user;
    t_card;
    end_of_test;
  end
endmodule : testbench
